/* File: verif/core_model.sv */
// Core model: acks vectors after a delay, returns on request
// Assumes: bench calls ret() to end a routine
`timescale 1ns/10ps
`default_nettype none
module core_model (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       vector_valid,
  input  wire logic [7:0] vector_addr,
  input  wire logic [3:0] ack_delay,
  output logic            vector_ack,
  output logic            service_done,
  output logic [7:0]      taken_q,
  output logic [7:0]      last_addr_q
);
  logic [3:0] wait_q;
  initial service_done = 1'b0;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      vector_ack <= 1'b0;
      wait_q <= 4'h0;
      taken_q <= 8'h0;
      last_addr_q <= 8'h0;
    end else if (vector_valid && vector_ack) begin
      vector_ack <= 1'b0;
      wait_q <= 4'h0;
      taken_q <= taken_q + 8'h1;
      last_addr_q <= vector_addr;
    end else if (vector_valid) begin
      vector_ack <= (wait_q >= ack_delay);
      wait_q <= wait_q + 4'h1;
    end
  end
  task automatic ret();
    @(posedge aclk);
    service_done <= 1'b1;
    @(posedge aclk);
    service_done <= 1'b0;
  endtask : ret
endmodule : core_model
`default_nettype wire

/* File: verif/four_level_interrupt_controller_tb_top.sv */
// Bench: registers, grants, nesting, status
// Assumes: core_model as core, checker bound
`timescale 1ns/10ps
`default_nettype none
module four_level_interrupt_controller_tb_top;
  typedef struct packed {
    logic [5:0] src, en, ph, pl;
    logic alt;
    logic [7:0] adr;
    logic [2:0] n;
  } row_t;
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [1:0] s_axi_bresp, s_axi_rresp, service_level, r;
  logic [3:0] pset, lvl, flags, ack_dly;
  logic vector_valid, vector_ack, service_done, in_service, irq;
  logic [7:0] vector_addr, taken_q, last_addr_q, a, t;
  int num_errors, checks, cyc;
  row_t rw;
  localparam logic [11:0] EN = irq_ctrl_pkg::ADDR_ENABLE, PH = irq_ctrl_pkg::ADDR_PRIO_HIGH;
  localparam logic [11:0] PL = irq_ctrl_pkg::ADDR_PRIO_LOW, ST = irq_ctrl_pkg::ADDR_STATUS;
  row_t rows [14] = '{
    '{6'h01, 6'h3F, 6'h0, 6'h0, 1'b0, 8'h03, 3'h1}, '{6'h02, 6'h3F, 6'h0, 6'h0, 1'b0, 8'h0B, 3'h1},
    '{6'h04, 6'h3F, 6'h0, 6'h0, 1'b0, 8'h13, 3'h1}, '{6'h08, 6'h3F, 6'h0, 6'h0, 1'b0, 8'h1B, 3'h1},
    '{6'h10, 6'h3F, 6'h0, 6'h0, 1'b0, 8'h23, 3'h1}, '{6'h10, 6'h3F, 6'h0, 6'h0, 1'b1, 8'h23, 3'h1},
    '{6'h20, 6'h3F, 6'h0, 6'h0, 1'b0, 8'h2B, 3'h1}, '{6'h20, 6'h3F, 6'h0, 6'h0, 1'b1, 8'h2B, 3'h1},
    '{6'h3F, 6'h3F, 6'h0, 6'h0, 1'b0, 8'h03, 3'h6}, '{6'h3E, 6'h3F, 6'h0, 6'h0, 1'b0, 8'h0B, 3'h5},
    '{6'h3F, 6'h3F, 6'h20, 6'h20, 1'b0, 8'h2B, 3'h6}, '{6'h3F, 6'h3F, 6'h10, 6'h0F, 1'b0, 8'h23, 3'h6},
    '{6'h3F, 6'h3F, 6'h0, 6'h08, 1'b0, 8'h1B, 3'h6}, '{6'h11, 6'h01, 6'h0, 6'h0, 1'b0, 8'h03, 3'h1}};
  irq_ctrl uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .ext0_request_set(pset[0]), .timer0_overflow_set(pset[1]),
    .ext1_request_set(pset[2]), .timer1_overflow_set(pset[3]), .receive_done_flag(lvl[0]),
    .transmit_done_flag(lvl[1]), .timer2_overflow_flag(lvl[2]), .timer2_external_flag(lvl[3]),
    .vector_valid, .vector_addr, .vector_source(), .vector_ack, .service_done, .service_level,
    .in_service, .ext0_request_flag(flags[0]), .timer0_overflow_flag(flags[1]),
    .ext1_request_flag(flags[2]), .timer1_overflow_flag(flags[3]), .irq);
  core_model core (.aclk, .aresetn, .vector_valid, .vector_addr, .ack_delay(ack_dly),
    .vector_ack, .service_done, .taken_q, .last_addr_q);
  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end
  always @(posedge aclk) cyc++;
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic end_sim();
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : end_sim
  ////////////////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [11:0] ad, input logic [31:0] dt, output logic [1:0] rs);
    @(posedge aclk);
    s_axi_awaddr <= ad;
    s_axi_wdata <= dt;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) begin
        rs = s_axi_bresp;
        s_axi_bready <= 1'b0;
        break;
      end
    end
  endtask : wr
  task automatic rd(input logic [11:0] ad, output logic [31:0] dt, output logic [1:0] rs);
    @(posedge aclk);
    s_axi_araddr <= ad;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        dt = s_axi_rdata;
        rs = s_axi_rresp;
        s_axi_rready <= 1'b0;
        break;
      end
    end
  endtask : rd
  task automatic wrc(input logic [11:0] ad, input logic [31:0] dt);
    logic [1:0] rs;
    wr(ad, dt, rs);
    check("bresp", {30'h0, rs}, {30'h0, irq_ctrl_pkg::RESP_OKAY});
  endtask : wrc
  task automatic rdc(input string nm, input logic [11:0] ad, input logic [31:0] e);
    logic [31:0] dt;
    logic [1:0] rs;
    rd(ad, dt, rs);
    check(nm, {dt[31:2], rs}, {e[31:2], irq_ctrl_pkg::RESP_OKAY});
    check(nm, dt, e);
  endtask : rdc
  task automatic raise(input logic [5:0] s, input logic alt);
    @(posedge aclk);
    pset <= s[3:0];
    lvl <= {s[5] & alt, s[5] & ~alt, s[4] & alt, s[4] & ~alt};
    @(posedge aclk);
    pset <= 4'h0;
  endtask : raise
  task automatic take(output logic [7:0] ad);
    int n;
    n = 0;
    while (taken_q == t && n < 60) begin
      @(posedge aclk);
      n++;
    end
    check("grant", {31'h0, taken_q != t}, 32'h1);
    t = taken_q;
    ad = last_addr_q;
  endtask : take
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, pset, lvl, ack_dly} = '0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    wrc(irq_ctrl_pkg::ADDR_CONFIG, 32'h3);
    for (int i = 0; i < 14; i++) begin
      rw = rows[i];
      ack_dly <= 4'(i % 3);
      wrc(PH, {26'h0, rw.ph});
      wrc(PL, {26'h0, rw.pl});
      wrc(EN, {26'h0, rw.en});
      t = taken_q;
      raise(rw.src, rw.alt);
      repeat (4) @(posedge aclk);
      check("gated", {23'h0, vector_valid, taken_q}, {24'h0, t});
      wrc(EN, {24'h0, 2'h2, rw.en});
      for (int k = 0; k < rw.n; k++) begin
        take(a);
        if (k == 0) check("first vector", {24'h0, a}, {24'h0, rw.adr});
        if (a[5:3] == 3'h4) lvl[1:0] <= 2'h0;
        if (a[5:3] == 3'h5) lvl[3:2] <= 2'h0;
        core.ret();
      end
      lvl <= 4'h0;
      repeat (6) @(posedge aclk);
      check("drained", {23'h0, vector_valid, taken_q}, {24'h0, t});
      check("hw clear", {28'h0, flags}, 32'h0);
      $display("row %0d done", i);
    end
    wrc(PH, 32'h10);
    wrc(PL, 32'h19);
    wrc(EN, 32'h9F);
    raise(6'h08, 1'b0);
    take(a);
    check("level one", {21'h0, in_service, service_level, a}, {21'h0, 3'h5, 8'h1B});
    raise(6'h01, 1'b0);
    repeat (6) @(posedge aclk);
    check("equal held", {24'h0, taken_q}, {24'h0, t});
    raise(6'h10, 1'b0);
    take(a);
    check("preempt", {21'h0, in_service, service_level, a}, {21'h0, 3'h7, 8'h23});
    lvl <= 4'h0;
    core.ret();
    repeat (2) @(posedge aclk);
    check("resume", {29'h0, in_service, service_level}, 32'h5);
    core.ret();
    take(a);
    check("pending", {24'h0, a}, 32'h03);
    core.ret();
    repeat (2) @(posedge aclk);
    check("idle", {31'h0, in_service}, 32'h0);
    $display("nesting done");
    check("irq masked", {31'h0, irq}, 32'h0);
    wrc(irq_ctrl_pkg::ADDR_MASK, 32'h7);
    check("irq on", {31'h0, irq}, 32'h1);
    rdc("status", ST, 32'h7);
    @(posedge aclk);
    check("irq off", {31'h0, irq}, 32'h0);
    rdc("status clear", ST, 32'h0);
    $display("status done");
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rdc("enable reset", EN, 32'h0);
    rdc("high reset", PH, 32'h0);
    rdc("low reset", PL, 32'h0);
    wrc(EN, 32'hFFFFFFFF);
    rdc("enable rw", EN, 32'hBF);
    wrc(PH, 32'hFF);
    rdc("high rw", PH, 32'h3F);
    wrc(PL, 32'hFF);
    rdc("low rw", PL, 32'h3F);
    rd(12'h7F0, d, r);
    check("unmapped", {30'h0, r}, {30'h0, irq_ctrl_pkg::RESP_SLVERR});
    $display("registers done");
    end_sim();
  end
  initial begin
    wait (cyc == 20000);
    num_errors++;
    end_sim();
  end
endmodule : four_level_interrupt_controller_tb_top
`default_nettype wire

/* File: verif/irq_ctrl_assertions.sv */
// Checker: vector offer, nesting and flag clears
// Assumes: bound to irq_ctrl, one clock, sync active-low reset
`timescale 1ns/10ps
`default_nettype none
module irq_ctrl_assertions (
  input wire logic       aclk,
  input wire logic       aresetn,
  input wire logic       vector_valid,
  input wire logic [7:0] vector_addr,
  input wire logic [2:0] vector_source,
  input wire logic       vector_ack,
  input wire logic       service_done,
  input wire logic [1:0] service_level,
  input wire logic       in_service,
  input wire logic       timer0_overflow_set,
  input wire logic       timer1_overflow_set,
  input wire logic       timer0_overflow_flag,
  input wire logic       timer1_overflow_flag
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_take; vector_valid && vector_ack; endsequence
  sequence s_ret; service_done && in_service && !(vector_valid && vector_ack); endsequence
  property p_vec_map;
    vector_valid |-> vector_source < 3'h6 && vector_addr == {2'h0, vector_source, 3'h3};
  endproperty
  property p_vec_hold;
    vector_valid && !vector_ack |=> vector_valid && $stable(vector_addr) && $stable(vector_source);
  endproperty
  property p_take; s_take |=> !vector_valid && in_service; endproperty
  property p_preempt;
    s_take ##0 in_service |=> service_level > $past(service_level);
  endproperty
  property p_return; s_ret |=> !in_service || service_level < $past(service_level); endproperty
  property p_level_hold;
    !service_done && !(vector_valid && vector_ack) |=> $stable(service_level) && $stable(in_service);
  endproperty
  property p_t0_clr;
    s_take ##0 (vector_source == 3'h1 && !timer0_overflow_set) |=> !timer0_overflow_flag;
  endproperty
  property p_t1_clr;
    s_take ##0 (vector_source == 3'h3 && !timer1_overflow_set) |=> !timer1_overflow_flag;
  endproperty
  property p_t0_set; timer0_overflow_set |=> timer0_overflow_flag; endproperty
  a_vec_map: assert property (p_vec_map) else $error("bad vector");
  a_vec_hold: assert property (p_vec_hold) else $error("offer moved");
  a_take: assert property (p_take) else $error("take not in service");
  a_preempt: assert property (p_preempt) else $error("nested grant not higher");
  a_return: assert property (p_return) else $error("no pop");
  a_level_hold: assert property (p_level_hold) else $error("level moved");
  a_t0_clr: assert property (p_t0_clr) else $error("t0 not cleared");
  a_t1_clr: assert property (p_t1_clr) else $error("t1 not cleared");
  a_t0_set: assert property (p_t0_set) else $error("t0 not set");
endmodule : irq_ctrl_assertions
bind irq_ctrl irq_ctrl_assertions chk (.aclk, .aresetn, .vector_valid, .vector_addr,
  .vector_source, .vector_ack, .service_done, .service_level, .in_service,
  .timer0_overflow_set, .timer1_overflow_set, .timer0_overflow_flag, .timer1_overflow_flag);
`default_nettype wire

/* File: verilog/irq_arb_if.sv */
// Interface: arbitration request from the top to the level resolver
// Assumes: single clock domain, combinational resolver
`timescale 1ns/10ps
`default_nettype none
interface irq_arb_if;
  logic [5:0] pending;
  logic [5:0] prio_high;
  logic [5:0] prio_low;
  logic       found;
  logic [2:0] winner;
  logic [1:0] level;
  modport ctrl (output pending, output prio_high, output prio_low,
                input found, input winner, input level);
  modport arb  (input pending, input prio_high, input prio_low,
                output found, output winner, output level);
endinterface : irq_arb_if
`default_nettype wire

/* File: verilog/irq_ctrl.sv */
// Four-level nested interrupt controller with AXI4-Lite register access
// Assumes: core handshakes vector_valid/vector_ack and pulses service_done on return
//
// Behaviour
// - Six request sources, each assignable to one of four levels.
// - The high-priority register holds one high bit per source in bits 0 to 5, 6 and 7 unused.
// - A source's level is its high bit and low bit taken as a two-bit number.
// - A request is granted only while no equal or higher level is in service.
// - A request at or below the serviced level waits until that service finishes.
// - A strictly higher level preempts, and the preempted service resumes afterwards.
// - Nesting is tracked so the preempted level becomes active again on return.
// - Ties at one level go to the lowest polling position, external 0 first, timer 2 last.
// - Vectors are 03, 0B, 13, 1B, 23 and 2B hex for the six sources in order.
// - On vectoring, edge external flags and timer 0 and 1 flags are cleared by hardware.
// - With the global enable clear nothing is granted.
// - The enable register holds per-source enables in bits 0 to 5 and global in bit 7.
`timescale 1ns/10ps
`default_nettype none
module irq_ctrl (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite slave
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Request flags from peripherals: one-cycle set pulses for external 0/1 and timer 0/1, held flags for serial and timer 2
  input  wire logic        ext0_request_set,
  input  wire logic        ext1_request_set,
  input  wire logic        timer0_overflow_set,
  input  wire logic        timer1_overflow_set,
  input  wire logic        receive_done_flag,
  input  wire logic        transmit_done_flag,
  input  wire logic        timer2_overflow_flag,
  input  wire logic        timer2_external_flag,
  // Core side
  output logic             vector_valid,
  output logic [7:0]       vector_addr,
  output logic [2:0]       vector_source,
  input  wire logic        vector_ack,
  input  wire logic        service_done,
  output logic [1:0]       service_level,
  output logic             in_service,
  output logic             ext0_request_flag,
  output logic             ext1_request_flag,
  output logic             timer0_overflow_flag,
  output logic             timer1_overflow_flag,
  output logic             irq
);
  //////////////////////////////////////////////////////////////////////////////
  // Registers
  logic [7:0] enable_q;
  logic [5:0] prio_high_q;
  logic [5:0] prio_low_q;
  logic [1:0] edge_mode_q;
  logic [2:0] status_q;
  logic [2:0] mask_q;
  logic       ext0_q;
  logic       ext1_q;
  logic       tf0_q;
  logic       tf1_q;
  logic       vec_valid_q;
  logic [7:0] vec_addr_q;
  logic [2:0] vec_src_q;
  logic [1:0] vec_level_q;

  logic       aw_held_q;
  logic       w_held_q;
  logic [11:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0]  w_strb_q;
  logic        bvalid_q;
  logic [1:0]  bresp_q;
  logic        rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0]  rresp_q;

  //////////////////////////////////////////////////////////////////////////////
  // Request gathering and arbitration
  logic [5:0] raw_req;
  logic [5:0] pending;
  logic       nest_busy;
  logic [1:0] nest_top;
  logic [3:0] nest_active;
  logic       grant;
  logic       took;
  logic       evt_preempt;

  assign raw_req[irq_ctrl_pkg::SRC_EXT0]   = ext0_q;
  assign raw_req[irq_ctrl_pkg::SRC_TIMER0] = tf0_q;
  assign raw_req[irq_ctrl_pkg::SRC_EXT1]   = ext1_q;
  assign raw_req[irq_ctrl_pkg::SRC_TIMER1] = tf1_q;
  assign raw_req[irq_ctrl_pkg::SRC_SERIAL] = receive_done_flag | transmit_done_flag;
  assign raw_req[irq_ctrl_pkg::SRC_TIMER2] = timer2_overflow_flag | timer2_external_flag;

  // Global gate and per-source enables
  assign pending = enable_q[irq_ctrl_pkg::BIT_GLOBAL_EN] ?
                   (raw_req & enable_q[5:0]) : 6'h00;

  irq_arb_if arb_bus ();
  assign arb_bus.pending   = pending;
  assign arb_bus.prio_high = prio_high_q;
  assign arb_bus.prio_low  = prio_low_q;

  irq_level_arb u_arb (
    .a (arb_bus)
  );

  irq_nest_stack u_nest (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .push       (took),
    .push_level (vec_level_q),
    .pop        (service_done && !took),
    .busy       (nest_busy),
    .top_level  (nest_top),
    .active     (nest_active)
  );

  // Grant only above the level in service; equal or lower keeps waiting
  assign grant = arb_bus.found && !vec_valid_q &&
                 (!nest_busy || (arb_bus.level > nest_top));
  assign took  = vec_valid_q && vector_ack;
  assign evt_preempt = took && nest_busy;

  //////////////////////////////////////////////////////////////////////////////
  // Vector offer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      vec_valid_q <= 1'b0;
      vec_addr_q  <= 8'h00;
      vec_src_q   <= 3'h0;
      vec_level_q <= 2'h0;
    end else if (took) begin
      vec_valid_q <= 1'b0;
    end else if (grant) begin
      vec_valid_q <= 1'b1;
      vec_addr_q  <= irq_ctrl_pkg::VECTOR_TABLE[arb_bus.winner];
      vec_src_q   <= arb_bus.winner;
      vec_level_q <= arb_bus.level;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Hardware-cleared request flags; a new set wins over the vectoring clear
  logic clr_x0;
  logic clr_x1;
  logic clr_t0;
  logic clr_t1;
  assign clr_x0 = took && vec_src_q == 3'(irq_ctrl_pkg::SRC_EXT0) && edge_mode_q[0];
  assign clr_x1 = took && vec_src_q == 3'(irq_ctrl_pkg::SRC_EXT1) && edge_mode_q[1];
  assign clr_t0 = took && vec_src_q == 3'(irq_ctrl_pkg::SRC_TIMER0);
  assign clr_t1 = took && vec_src_q == 3'(irq_ctrl_pkg::SRC_TIMER1);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ext0_q <= 1'b0;
      ext1_q <= 1'b0;
      tf0_q  <= 1'b0;
      tf1_q  <= 1'b0;
    end else begin
      // Level-mode external flag follows its pin pulse each cycle
      ext0_q <= ext0_request_set | (ext0_q & ~clr_x0 & edge_mode_q[0]);
      ext1_q <= ext1_request_set | (ext1_q & ~clr_x1 & edge_mode_q[1]);
      tf0_q  <= timer0_overflow_set | (tf0_q & ~clr_t0);
      tf1_q  <= timer1_overflow_set | (tf1_q & ~clr_t1);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write path
  logic        wr_fire;
  logic [11:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0]  wr_strb;
  logic        wr_hit;
  assign s_axi_awready = !aw_held_q && !bvalid_q;
  assign s_axi_wready  = !w_held_q && !bvalid_q;
  assign wr_addr = aw_held_q ? aw_addr_q : s_axi_awaddr;
  assign wr_data = w_held_q ? w_data_q : s_axi_wdata;
  assign wr_strb = w_held_q ? w_strb_q : s_axi_wstrb;
  assign wr_fire = !bvalid_q && (aw_held_q || s_axi_awvalid) && (w_held_q || s_axi_wvalid);
  assign wr_hit  = wr_addr == irq_ctrl_pkg::ADDR_ENABLE || wr_addr == irq_ctrl_pkg::ADDR_PRIO_HIGH
                || wr_addr == irq_ctrl_pkg::ADDR_PRIO_LOW || wr_addr == irq_ctrl_pkg::ADDR_MASK
                || wr_addr == irq_ctrl_pkg::ADDR_CONFIG || wr_addr == irq_ctrl_pkg::ADDR_STATUS
                || wr_addr == irq_ctrl_pkg::ADDR_SERVICE;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      w_held_q  <= 1'b0;
      aw_addr_q <= 12'h000;
      w_data_q  <= 32'h00000000;
      w_strb_q  <= 4'h0;
      bvalid_q  <= 1'b0;
      bresp_q   <= irq_ctrl_pkg::RESP_OKAY;
    end else begin
      if (wr_fire) begin
        aw_held_q <= 1'b0;
        w_held_q  <= 1'b0;
        bvalid_q  <= 1'b1;
        bresp_q   <= wr_hit ? irq_ctrl_pkg::RESP_OKAY : irq_ctrl_pkg::RESP_SLVERR;
      end else begin
        if (s_axi_awvalid && s_axi_awready) begin
          aw_held_q <= 1'b1;
          aw_addr_q <= s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
          w_held_q <= 1'b1;
          w_data_q <= s_axi_wdata;
          w_strb_q <= s_axi_wstrb;
        end
        if (bvalid_q && s_axi_bready) begin
          bvalid_q <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      enable_q    <= irq_ctrl_pkg::ENABLE_RST;
      prio_high_q <= irq_ctrl_pkg::PRIO_RST[5:0];
      prio_low_q  <= irq_ctrl_pkg::PRIO_RST[5:0];
      mask_q      <= 3'h0;
      edge_mode_q <= 2'h0;
    end else if (wr_fire && wr_strb[0]) begin
      unique case (wr_addr)
        irq_ctrl_pkg::ADDR_ENABLE:    enable_q <= {wr_data[7], 1'b0, wr_data[5:0]};
        irq_ctrl_pkg::ADDR_PRIO_HIGH: prio_high_q <= wr_data[5:0];
        irq_ctrl_pkg::ADDR_PRIO_LOW:  prio_low_q <= wr_data[5:0];
        irq_ctrl_pkg::ADDR_MASK:      mask_q <= wr_data[2:0];
        irq_ctrl_pkg::ADDR_CONFIG:    edge_mode_q <= wr_data[1:0];
        default: ;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read path; reading status clears it, new events win
  logic        rd_fire;
  logic [31:0] rd_word;
  logic        rd_hit;
  logic [2:0]  evt;
  assign s_axi_arready = !rvalid_q;
  assign rd_fire = s_axi_arvalid && !rvalid_q;
  assign evt = {took && !evt_preempt ? 1'b0 : 1'b0, 1'b0, 1'b0}
             | ({service_done && !took, evt_preempt, took});

  always_comb begin
    rd_word = 32'h00000000;
    rd_hit  = 1'b1;
    unique case (s_axi_araddr)
      irq_ctrl_pkg::ADDR_ENABLE:    rd_word[7:0] = enable_q;
      irq_ctrl_pkg::ADDR_PRIO_HIGH: rd_word[5:0] = prio_high_q;
      irq_ctrl_pkg::ADDR_PRIO_LOW:  rd_word[5:0] = prio_low_q;
      irq_ctrl_pkg::ADDR_STATUS:    rd_word[2:0] = status_q;
      irq_ctrl_pkg::ADDR_MASK:      rd_word[2:0] = mask_q;
      irq_ctrl_pkg::ADDR_CONFIG:    rd_word[1:0] = edge_mode_q;
      irq_ctrl_pkg::ADDR_SERVICE:   rd_word[13:0] = {pending, nest_active, nest_top, 1'b0,
                                                      nest_busy};
      default:                      rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h00000000;
      rresp_q  <= irq_ctrl_pkg::RESP_OKAY;
    end else if (rd_fire) begin
      rvalid_q <= 1'b1;
      rdata_q  <= rd_word;
      rresp_q  <= rd_hit ? irq_ctrl_pkg::RESP_OKAY : irq_ctrl_pkg::RESP_SLVERR;
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_q <= 3'h0;
    end else if (rd_fire && s_axi_araddr == irq_ctrl_pkg::ADDR_STATUS) begin
      status_q <= evt;
    end else begin
      status_q <= status_q | evt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp  = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata  = rdata_q;
  assign s_axi_rresp  = rresp_q;
  assign vector_valid  = vec_valid_q;
  assign vector_addr   = vec_addr_q;
  assign vector_source = vec_src_q;
  assign service_level = nest_top;
  assign in_service    = nest_busy;
  assign ext0_request_flag    = ext0_q;
  assign ext1_request_flag    = ext1_q;
  assign timer0_overflow_flag = tf0_q;
  assign timer1_overflow_flag = tf1_q;
  assign irq = |(status_q & mask_q);
endmodule : irq_ctrl
`default_nettype wire

/* File: verilog/irq_ctrl_pkg.sv */
// Package: register map, field positions, vectors and enums of the interrupt controller
// Assumes: included before all other design files
package irq_ctrl_pkg;
  localparam int          NUM_SRC       = 6;
  localparam int          LEVEL_W       = 2;
  localparam int          ADDR_W        = 12;
  localparam logic [11:0] OFS_ENABLE    = 12'h0A8;
  localparam logic [11:0] OFS_PRIO_HIGH = 12'h0B7;
  localparam logic [11:0] OFS_PRIO_LOW  = 12'h0B8;
  // Word-aligned stand-ins for the byte offsets above (each offset times four; 0B7 is not a multiple of four)
  localparam logic [11:0] ADDR_ENABLE    = 12'h2A0;
  localparam logic [11:0] ADDR_PRIO_HIGH = 12'h2DC;
  localparam logic [11:0] ADDR_PRIO_LOW  = 12'h2E0;
  localparam logic [11:0] ADDR_STATUS    = 12'h400;
  localparam logic [11:0] ADDR_MASK      = 12'h404;
  localparam logic [11:0] ADDR_CONFIG    = 12'h408;
  localparam logic [11:0] ADDR_SERVICE   = 12'h40C;
  localparam int          BIT_GLOBAL_EN = 7;
  localparam logic [7:0]  ENABLE_RST    = 8'h00;
  localparam logic [7:0]  PRIO_RST      = 8'h00;
  localparam logic [5:0]  SRC_MASK      = 6'h3F;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;
  // Source index order is also polling order
  localparam int SRC_EXT0   = 0;
  localparam int SRC_TIMER0 = 1;
  localparam int SRC_EXT1   = 2;
  localparam int SRC_TIMER1 = 3;
  localparam int SRC_SERIAL = 4;
  localparam int SRC_TIMER2 = 5;
  localparam logic [7:0] VECTOR_TABLE [NUM_SRC] = '{8'h03, 8'h0B, 8'h13, 8'h1B, 8'h23, 8'h2B};
  // Status bits of the event register
  localparam int EVT_GRANT   = 0;
  localparam int EVT_PREEMPT = 1;
  localparam int EVT_RETURN  = 2;
  localparam int EVT_W       = 3;
endpackage : irq_ctrl_pkg

/* File: verilog/irq_level_arb.sv */
// Level resolver: picks the highest level, ties broken by polling order
// Assumes: inputs stable within a cycle; purely combinational
`timescale 1ns/10ps
`default_nettype none
module irq_level_arb (
  irq_arb_if.arb a
);
  logic [1:0] lvl [6];
  genvar g;
  generate
    for (g = 0; g < 6; g++) begin : g_lvl
      assign lvl[g] = {a.prio_high[g], a.prio_low[g]};
    end
  endgenerate
  always_comb begin
    a.found  = 1'b0;
    a.winner = 3'h0;
    a.level  = 2'h0;
    // Descending index so lower index wins on equal level
    for (int i = 5; i >= 0; i--) begin
      if (a.pending[i] && (!a.found || lvl[i] >= a.level)) begin
        a.found  = 1'b1;
        a.winner = 3'(i);
        a.level  = lvl[i];
      end
    end
  end
endmodule : irq_level_arb
`default_nettype wire

/* File: verilog/irq_nest_stack.sv */
// Nesting tracker: one in-service bit per level, top set bit is the active level
// Assumes: push only of a level above the current top
`timescale 1ns/10ps
`default_nettype none
module irq_nest_stack (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       push,
  input  wire logic [1:0] push_level,
  input  wire logic       pop,
  output logic            busy,
  output logic [1:0]      top_level,
  output logic [3:0]      active
);
  logic [3:0] active_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      active_q <= 4'h0;
    end else if (push) begin
      active_q <= active_q | (4'h1 << push_level);
    end else if (pop) begin
      // Clearing the top bit exposes the preempted level again
      active_q <= active_q & ~(4'h1 << top_level);
    end
  end
  always_comb begin
    top_level = 2'h0;
    for (int i = 0; i < 4; i++) begin
      if (active_q[i]) begin
        top_level = 2'(i);
      end
    end
  end
  assign busy   = |active_q;
  assign active = active_q;
endmodule : irq_nest_stack
`default_nettype wire
